// >>> rtl/urx_defs.svh
// Functional notes
// - Select 00 or 01: interrupt on every word moved into the FIFO.
// - Select 10: interrupt when a transfer leaves exactly three words.
// - Select 11: interrupt when a transfer fills the FIFO with four words.
// - FIFO holds four words; a fifth finished word is not stored and sets overrun.
// - Data available bit 0 is 1 while the FIFO holds a word.
// - Reading an empty holding register returns old value, no shift.
// - Each holding read pops; error flags follow the new top word.
// - Device reset empties the FIFO; sleep entry or wake keeps it.
// - Receive interrupt is a one-cycle pulse, not a level.
// - Overrun bit 1 set when FIFO full and a finished word arrives.
// - While overrun is set nothing shifts in; software clears it.
// - Framing bit 2 set on a zero stop sample; both stops checked.
// - Framing flag is read-only, stored per word, cleared on reset.
// - Parity bit 3 set on bad parity in odd/even mode, stored per word.
// - Idle bit 4 is 0 from start detection until stop completion.
// - Long break completes a frame of zeros with framing error set.
// - After a break, wait for a high line before seeking a start.
// - Address detect in 9-bit mode interrupts on every ninth-bit-one word.
// - Loopback feeds the transmit line to the receiver, pin ignored.
// - Bit rate is clock over sixteen times divisor plus one.
// - Sleep aborts reception, drives transmit pin high, keeps registers.
// - Wake enabled and module on: falling pin edge in sleep interrupts.
// - Disable empties FIFO, clears flags, sets idle, keeps select bits.
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_OFS_MODE    3'h0
`define URX_OFS_STATUS  3'h1
`define URX_OFS_RXREG   3'h2
`define URX_OFS_BAUD    3'h3
`define URX_MODE_EN     15
`define URX_MODE_WAKE   7
`define URX_MODE_LOOP   6
`define URX_MODE_PDS    1
`define URX_MODE_STOP   0
`define URX_MODE_MASK   16'h80C7
`define URX_MODE_RST    16'h0000
`define URX_BAUD_RST    16'h0000
`define URX_ISEL_RST    2'h0
`define URX_STA_ISEL    6
`define URX_STA_ADDR    5
`define URX_STA_IDLE    4
`define URX_STA_PARITY_ERR_FLAG    3
`define URX_STA_FRAMING_ERR_FLAG    2
`define URX_STA_RX_OVERRUN_FLAG    1
`define URX_STA_AVAIL   0
`define URX_PDS_EVEN    2'h1
`define URX_PDS_ODD     2'h2
`define URX_PDS_NINE    2'h3
`define URX_ISEL_3      2'h2
`define URX_ISEL_4      2'h3
`define URX_LVL_3       3'h3
`define URX_LVL_4       3'h4
`define URX_SUB_MID     4'h7
`define URX_LAST_8      4'h7
`define URX_LAST_9      4'h8
`endif

// >>> rtl/urx_pkg.sv
package urx_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_start,
      st_data,
      st_par,
      st_stop1,
      st_stop2,
      st_brk
   } urx_state_t;
   typedef struct packed {
      logic       framing_err_flag;
      logic       parity_err_flag;
      logic [8:0] data;
   } urx_word_t;
endpackage

// >>> rtl/urx_receiver.sv
`timescale 1ns/10ps
`include "urx_defs.svh"
module urx_receiver #(
   parameter int DEPTH = 4,
   parameter int PW    = $clog2(DEPTH)
) (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [2:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        serial_in_pin,
   input  wire logic        tx_line,
   input  wire logic        sleep_mode,
   output logic             serial_out_pin,
   output logic             rx_irq_flag
);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   urx_pkg::urx_state_t state;
   urx_pkg::urx_state_t next_state;
   logic [3:0]          sub;
   logic [3:0]          next_sub;
   logic [3:0]          bitn;
   logic [3:0]          next_bitn;
   logic [8:0]          shreg;
   logic [8:0]          next_shreg;
   logic                parity_err_flag_q;
   logic                next_parity_err_flag;
   logic                framing_err_flag_q;
   logic                next_framing_err_flag;
   logic [15:0]         bcnt;
   logic [15:0]         next_bcnt;

   logic [15:0]         mode_q;
   logic [15:0]         next_mode;
   logic [15:0]         baud_q;
   logic [15:0]         next_baud;
   logic [1:0]          isel;
   logic [1:0]          next_isel;
   logic                addr_en;
   logic                next_addr_en;
   logic                rx_overrun_flag;
   logic                next_rx_overrun_flag;
   urx_pkg::urx_word_t  mem      [DEPTH];
   urx_pkg::urx_word_t  next_mem [DEPTH];
   urx_pkg::urx_word_t  hold_q;
   urx_pkg::urx_word_t  next_hold;
   logic [PW-1:0]       rp;
   logic [PW-1:0]       next_rp;
   logic [PW-1:0]       wp;
   logic [PW-1:0]       next_wp;
   logic [PW:0]         cnt;
   logic [PW:0]         next_cnt;
   logic [15:0]         next_rdata;
   logic                next_irq;
   logic                next_out;
   logic                pin_q;

   logic                en;
   logic                run;
   logic                tick;
   logic                mid;
   logic                nine;
   logic                rx_line;
   logic                done;
   urx_pkg::urx_word_t  word;
   urx_pkg::urx_word_t  top;
   logic                pop;
   logic                full;
   logic                push;
   logic                ovf;
   logic                sel_hit;
   logic                adr_mode;
   logic                wake;
   logic                idle;
   logic [15:0]         sta;

   assign en      = mode_q[`URX_MODE_EN];
   assign run     = en && !sleep_mode;
   assign nine    = mode_q[`URX_MODE_PDS +: 2] == `URX_PDS_NINE;
   assign rx_line = mode_q[`URX_MODE_LOOP] ? tx_line : serial_in_pin;
   assign tick    = run && (bcnt == baud_q);
   assign mid     = sub == `URX_SUB_MID;
   assign idle    = (state == urx_pkg::st_idle) || (state == urx_pkg::st_brk);
   assign top     = (cnt != '0) ? mem[rp] : hold_q;

   // Bit timing and frame sequencing
   always_comb begin
      next_state = state;
      next_sub   = sub;
      next_bitn  = bitn;
      next_shreg = shreg;
      next_parity_err_flag  = parity_err_flag_q;
      next_framing_err_flag  = framing_err_flag_q;
      done       = 1'b0;
      next_bcnt  = (!run || tick) ? 16'h0000 : bcnt + 16'h0001;
      word.data  = nine ? shreg : {1'b0, shreg[8:1]};
      word.framing_err_flag  = framing_err_flag_q || !rx_line;
      word.parity_err_flag  = parity_err_flag_q;
      if (!run) begin
         next_state = urx_pkg::st_idle;
         next_sub   = 4'h0;
      end else if (tick) begin
         next_sub = sub + 4'h1;
         case (state)
            urx_pkg::st_idle: begin
               if (!rx_overrun_flag && !rx_line) begin
                  next_state = urx_pkg::st_start;
                  next_sub   = 4'h0;
                  next_bitn  = 4'h0;
                  next_parity_err_flag  = 1'b0;
                  next_framing_err_flag  = 1'b0;
               end
            end
            urx_pkg::st_start: begin
               if (mid) begin
                  next_state = rx_line ? urx_pkg::st_idle : urx_pkg::st_data;
               end
            end
            urx_pkg::st_data: begin
               if (mid) begin
                  next_shreg = {rx_line, shreg[8:1]};
                  next_bitn  = bitn + 4'h1;
                  if (bitn == (nine ? `URX_LAST_9 : `URX_LAST_8)) begin
                     if (!nine && mode_q[`URX_MODE_PDS +: 2] != 2'h0) begin
                        next_state = urx_pkg::st_par;
                     end else begin
                        next_state = urx_pkg::st_stop1;
                     end
                  end
               end
            end
            urx_pkg::st_par: begin
               if (mid) begin
                  if (mode_q[`URX_MODE_PDS +: 2] == `URX_PDS_EVEN) begin
                     next_parity_err_flag = ^{shreg[8:1], rx_line};
                  end else begin
                     next_parity_err_flag = ~^{shreg[8:1], rx_line};
                  end
                  next_state = urx_pkg::st_stop1;
               end
            end
            urx_pkg::st_stop1,
            urx_pkg::st_stop2: begin
               if (mid) begin
                  next_framing_err_flag = word.framing_err_flag;
                  if (state == urx_pkg::st_stop1 && mode_q[`URX_MODE_STOP]) begin
                     next_state = urx_pkg::st_stop2;
                  end else begin
                     done       = 1'b1;
                     next_state = rx_line ? urx_pkg::st_idle : urx_pkg::st_brk;
                  end
               end
            end
            urx_pkg::st_brk: begin
               if (rx_line) begin
                  next_state = urx_pkg::st_idle;
               end
            end
            default: begin
               next_state = urx_pkg::st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state  <= urx_pkg::st_idle;
         sub    <= 4'h0;
         bitn   <= 4'h0;
         shreg  <= 9'h000;
         parity_err_flag_q <= 1'b0;
         framing_err_flag_q <= 1'b0;
         bcnt   <= 16'h0000;
      end else begin
         state  <= next_state;
         sub    <= next_sub;
         bitn   <= next_bitn;
         shreg  <= next_shreg;
         parity_err_flag_q <= next_parity_err_flag;
         framing_err_flag_q <= next_framing_err_flag;
         bcnt   <= next_bcnt;
      end
   end

   // Registers, receive FIFO and interrupt pulse
   always_comb begin
      next_mode    = mode_q;
      next_baud    = baud_q;
      next_isel    = isel;
      next_addr_en = addr_en;
      next_mem     = mem;
      next_hold    = hold_q;
      next_rp      = rp;
      next_wp      = wp;
      next_cnt     = cnt;
      next_rdata   = 16'h0000;
      pop          = rd && (addr == `URX_OFS_RXREG) && (cnt != '0);
      full         = (cnt == FULL) && !pop;
      push         = done && !full;
      ovf          = done && full;
      if (push) begin
         next_mem[wp] = word;
         next_wp      = wp + 1'b1;
      end
      if (pop) begin
         next_hold = mem[rp];
         next_rp   = rp + 1'b1;
      end
      case ({push, pop})
         2'b10:   next_cnt = cnt + 1'b1;
         2'b01:   next_cnt = cnt - 1'b1;
         default: next_cnt = cnt;
      endcase
      // Set wins over a software clear in the same cycle
      next_rx_overrun_flag = ovf || (rx_overrun_flag && !(wr && addr == `URX_OFS_STATUS
                                    && !wdata[`URX_STA_RX_OVERRUN_FLAG]));
      if (wr) begin
         case (addr)
            `URX_OFS_MODE:   next_mode = wdata & `URX_MODE_MASK;
            `URX_OFS_STATUS: begin
               next_isel    = wdata[`URX_STA_ISEL +: 2];
               next_addr_en = wdata[`URX_STA_ADDR];
            end
            `URX_OFS_BAUD:   next_baud = wdata;
            default:         next_baud = baud_q;
         endcase
      end
      if (!en) begin
         next_cnt  = '0;
         next_rp   = '0;
         next_wp   = '0;
         next_rx_overrun_flag = 1'b0;
         next_hold = '0;
      end
      sel_hit  = !isel[1]
               || (isel == `URX_ISEL_3 && next_cnt == (PW+1)'(`URX_LVL_3))
               || (isel == `URX_ISEL_4 && next_cnt == (PW+1)'(`URX_LVL_4));
      adr_mode = addr_en && nine;
      wake     = sleep_mode && en && mode_q[`URX_MODE_WAKE]
               && pin_q && !serial_in_pin;
      next_irq = (push && (adr_mode ? word.data[8] : sel_hit)) || wake;
      next_out = sleep_mode ? 1'b1 : tx_line;
      sta      = 16'h0000;
      sta[`URX_STA_ISEL +: 2] = isel;
      sta[`URX_STA_ADDR]      = addr_en;
      sta[`URX_STA_IDLE]      = idle;
      sta[`URX_STA_PARITY_ERR_FLAG]      = top.parity_err_flag;
      sta[`URX_STA_FRAMING_ERR_FLAG]      = top.framing_err_flag;
      sta[`URX_STA_RX_OVERRUN_FLAG]      = rx_overrun_flag;
      sta[`URX_STA_AVAIL]     = cnt != '0;
      if (rd) begin
         case (addr)
            `URX_OFS_MODE:   next_rdata = mode_q;
            `URX_OFS_STATUS: next_rdata = sta;
            `URX_OFS_RXREG:  next_rdata = {7'h00, top.data};
            `URX_OFS_BAUD:   next_rdata = baud_q;
            default:         next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_q         <= `URX_MODE_RST;
         baud_q         <= `URX_BAUD_RST;
         isel           <= `URX_ISEL_RST;
         addr_en        <= 1'b0;
         rx_overrun_flag           <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         hold_q         <= '0;
         rp             <= '0;
         wp             <= '0;
         cnt            <= '0;
         rdata          <= 16'h0000;
         rx_irq_flag    <= 1'b0;
         serial_out_pin <= 1'b1;
         pin_q          <= 1'b1;
      end else begin
         mode_q         <= next_mode;
         baud_q         <= next_baud;
         isel           <= next_isel;
         addr_en        <= next_addr_en;
         rx_overrun_flag           <= next_rx_overrun_flag;
         mem            <= next_mem;
         hold_q         <= next_hold;
         rp             <= next_rp;
         wp             <= next_wp;
         cnt            <= next_cnt;
         rdata          <= next_rdata;
         rx_irq_flag    <= next_irq;
         serial_out_pin <= next_out;
         pin_q          <= serial_in_pin;
      end
   end

   AST_AVAIL_READ: assert property (
      rd && addr == `URX_OFS_STATUS |=> rdata[`URX_STA_AVAIL] == $past(cnt != '0))
      else $error("data available bit disagrees with fill level");
   AST_EMPTY_READ: assert property (
      rd && addr == `URX_OFS_RXREG && cnt == '0 && !push |=> cnt == '0 && rp == $past(rp))
      else $error("read of empty buffer moved the FIFO");
   AST_POP_LEVEL: assert property (
      pop && !push && en |=> cnt == $past(cnt) - 1'b1)
      else $error("holding read did not pop one word");
   AST_DEPTH: assert property (
      cnt <= FULL)
      else $error("FIFO level above depth");
   AST_OVR_SET: assert property (
      ovf |=> rx_overrun_flag)
      else $error("overrun not flagged");
   AST_OVR_HOLD: assert property (
      rx_overrun_flag && state == urx_pkg::st_idle && run |=> state == urx_pkg::st_idle)
      else $error("reception started during overrun");
   AST_IRQ_PULSE: assert property (
      rx_irq_flag |=> !rx_irq_flag)
      else $error("receive interrupt held as a level");
   AST_IRQ_ANY: assert property (
      push && !isel[1] && !adr_mode |=> rx_irq_flag)
      else $error("interrupt missing on word transfer");
   AST_IRQ_THREE: assert property (
      push && isel == `URX_ISEL_3 && !adr_mode && !wake
      |=> rx_irq_flag == (cnt == (PW+1)'(`URX_LVL_3)))
      else $error("three-word interrupt wrong");
   AST_IRQ_FULL: assert property (
      push && isel == `URX_ISEL_4 && !adr_mode && !wake
      |=> rx_irq_flag == (cnt == (PW+1)'(`URX_LVL_4)))
      else $error("full interrupt wrong");
   AST_DISABLE: assert property (
      !en |=> cnt == '0 && !rx_overrun_flag && idle)
      else $error("disable did not clear receiver");
   AST_SLEEP_TX: assert property (
      sleep_mode |=> serial_out_pin && idle)
      else $error("sleep did not abort or idle transmit pin");
   AST_FLAGS_TOP: assert property (
      rd && addr == `URX_OFS_STATUS && cnt != '0
      |=> rdata[`URX_STA_FRAMING_ERR_FLAG] == $past(mem[rp].framing_err_flag)
          && rdata[`URX_STA_PARITY_ERR_FLAG] == $past(mem[rp].parity_err_flag))
      else $error("error flags do not follow the top word");
   AST_IDLE_BUSY: assert property (
      rd && addr == `URX_OFS_STATUS && state == urx_pkg::st_data |=> !rdata[`URX_STA_IDLE])
      else $error("idle bit set during reception");
   AST_BREAK_DONE: assert property (
      push && !rx_line |=> state == urx_pkg::st_brk && cnt != '0)
      else $error("break frame not stored");
   AST_BREAK_WAIT: assert property (
      state == urx_pkg::st_brk && !rx_line |=> state != urx_pkg::st_start)
      else $error("low line after break taken as a start");
   AST_ADDR_HIT: assert property (
      push && adr_mode && word.data[8] |=> rx_irq_flag)
      else $error("address word gave no interrupt");
   AST_ADDR_DATA: assert property (
      push && adr_mode && !word.data[8] |=> !rx_irq_flag)
      else $error("data word interrupted in address mode");
   AST_LOOP_PIN: assert property (
      tick && mode_q[`URX_MODE_LOOP] && state == urx_pkg::st_idle
      && tx_line && !serial_in_pin |=> state == urx_pkg::st_idle)
      else $error("receive pin seen in loopback");
   AST_WAKE_IRQ: assert property (
      sleep_mode && en && mode_q[`URX_MODE_WAKE] && $fell(serial_in_pin) |=> rx_irq_flag)
      else $error("falling pin edge in sleep gave no interrupt");

   COV_PUSH: cover property (push ##1 rx_irq_flag);
   COV_OVR: cover property (ovf);
   COV_BREAK: cover property (state == urx_pkg::st_brk);
   COV_WAKE: cover property (wake ##1 rx_irq_flag);
endmodule

// >>> verification/urx_line_src.sv
`timescale 1ns/10ps
module urx_line_src (
   input  wire logic        mclk,
   input  wire logic        go,
   input  wire logic [15:0] frame,
   input  wire logic [4:0]  nbits,
   input  wire logic [15:0] div,
   output logic             line,
   output logic             busy
);
   initial begin
      line = 1'b1;
      busy = 1'b0;
   end
   // Bits go out LSB first; between frames the line rests high
   always @(posedge mclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         for (int i = 0; i < nbits; i++) begin
            line <= frame[i];
            repeat (16 * (div + 1)) @(posedge mclk);
         end
         line <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule

// >>> verification/tb_urx_receiver.sv
`timescale 1ns/10ps
module tb_urx_receiver;
   typedef struct {
      logic [1:0] pds;
      logic       two;
      logic [8:0] d;
      logic       bp;
      logic       bs;
   } urx_row_t;
   localparam logic [15:0] DIV = 16'h0002;
   logic        mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
   logic        sleep_mode = 1'b0, route = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0000, frame = 16'h0000, rdata, v;
   logic [4:0]  nbits = 5'h00;
   logic        src_line, busy, serial_out_pin, rx_irq_flag, pin, txl;
   int          n_errors = 0, tests_run = 0, irqs = 0, n, s, j;
   urx_row_t    r;
   urx_row_t    rows [8] = '{'{2'h0, 1'b0, 9'h0A5, 1'b0, 1'b0}, '{2'h1, 1'b0, 9'h03C, 1'b0, 1'b0},
                             '{2'h2, 1'b0, 9'h03C, 1'b1, 1'b0}, '{2'h0, 1'b1, 9'h081, 1'b0, 1'b1},
                             '{2'h3, 1'b0, 9'h1F0, 1'b0, 1'b0}, '{2'h1, 1'b1, 9'h000, 1'b0, 1'b0},
                             '{2'h2, 1'b1, 9'h0FF, 1'b0, 1'b0}, '{2'h3, 1'b0, 9'h155, 1'b0, 1'b1}};
   // In loopback the pin is held low so that any use of it would corrupt data
   assign pin = route ? 1'b0 : src_line;
   // Outside loopback the transmit line drops in sleep, so the forced high pin shows
   assign txl = route ? src_line : !sleep_mode;
   urx_line_src i_urx_line_src (.mclk(mclk), .go(go), .frame(frame), .nbits(nbits),
      .div(DIV), .line(src_line), .busy(busy));
   urx_receiver i_urx_receiver (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .serial_in_pin(pin), .tx_line(txl),
      .sleep_mode(sleep_mode), .serial_out_pin(serial_out_pin), .rx_irq_flag(rx_irq_flag));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (rx_irq_flag === 1'b1) irqs++;
   end
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wreg(input logic [2:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task rchk(input logic [2:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge mclk);
      check(v, e);
   endtask
   function logic [4:0] nbf(input logic [1:0] pds, input logic two);
      return 5'h0A + 5'(pds != 2'h0) + 5'(two);
   endfunction
   function logic [15:0] mkf(input logic [8:0] d, input logic [1:0] pds, input logic two,
                             input logic bp, input logic bs);
      logic [15:0] f;
      f = 16'hFFFF;
      f[0] = 1'b0;
      f[8:1] = d[7:0];
      if (pds != 2'h0) f[9] = (pds == 2'h3) ? d[8] : (((pds == 2'h1) ? ^d[7:0] : ~^d[7:0]) ^ bp);
      f[nbf(pds, two) - 1] = ~bs;
      return f;
   endfunction
   task send(input logic [15:0] f, input logic [4:0] nb, input logic chk);
      int k;
      frame <= f;
      nbits <= nb;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      if (chk) begin
         repeat (144) @(posedge mclk);
         rchk(3'h1, 16'h0000);
         check({15'h0, v[4]}, 16'h0000);
      end
      k = 0;
      while ((busy || k < 3) && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 2000) n_errors++;
      repeat (4) @(posedge mclk);
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rchk(3'h0, 16'h0000);
      rchk(3'h1, 16'h0010);
      rchk(3'h2, 16'h0000);
      rchk(3'h3, 16'h0000);
      rchk(3'h5, 16'h0000);
      wreg(3'h3, 16'hA5C3);
      rchk(3'h3, 16'hA5C3);
      wreg(3'h3, DIV);
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         wreg(3'h0, {13'h1000, r.pds, r.two});
         n = irqs;
         send(mkf(r.d, r.pds, r.two, r.bp, r.bs), nbf(r.pds, r.two), i == 0);
         check(16'(irqs - n), 16'h0001);
         rchk(3'h1, {12'h001, r.bp, r.bs, 2'h1});
         rchk(3'h2, (r.pds == 2'h3) ? {7'h00, r.d} : {8'h00, r.d[7:0]});
         rchk(3'h1, {12'h001, r.bp, r.bs, 2'h0});
      end
      for (s = 2; s < 4; s++) begin
         wreg(3'h1, {8'h00, s[1:0], 6'h00});
         wreg(3'h0, 16'h0000);
         rchk(3'h1, {8'h00, s[1:0], 6'h10});
         wreg(3'h0, 16'h8000);
         for (j = 0; j < 5; j++) begin
            n = irqs;
            send(mkf(9'(j + 16 * s), 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
            check(16'(irqs - n), (j == s) ? 16'h0001 : 16'h0000);
         end
         rchk(3'h1, {8'h00, s[1:0], 6'h13});
      end
      send(mkf(9'h077, 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
      for (j = 0; j < 4; j++) rchk(3'h2, 16'(48 + j));
      rchk(3'h1, 16'h00D2);
      rchk(3'h2, 16'h0033);
      rchk(3'h1, 16'h00D2);
      wreg(3'h1, 16'h0000);
      rchk(3'h1, 16'h0010);
      n = irqs;
      send(mkf(9'h05A, 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
      check(16'(irqs - n), 16'h0001);
      rchk(3'h2, 16'h005A);
      wreg(3'h0, 16'h8006);
      wreg(3'h1, 16'h00E0);
      n = irqs;
      send(mkf(9'h0AA, 2'h3, 1'b0, 1'b0, 1'b0), 5'h0B, 1'b0);
      check(16'(irqs - n), 16'h0000);
      send(mkf(9'h155, 2'h3, 1'b0, 1'b0, 1'b0), 5'h0B, 1'b0);
      check(16'(irqs - n), 16'h0001);
      rchk(3'h2, 16'h00AA);
      rchk(3'h2, 16'h0155);
      wreg(3'h1, 16'h0000);
      wreg(3'h0, 16'h8040);
      route <= 1'b1;
      send(mkf(9'h0C3, 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
      route <= 1'b0;
      rchk(3'h2, 16'h00C3);
      wreg(3'h0, 16'h8080);
      send(mkf(9'h03E, 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
      n = irqs;
      sleep_mode <= 1'b1;
      repeat (2) @(posedge mclk);
      check({15'h0, serial_out_pin}, 16'h0001);
      send(mkf(9'h0FF, 2'h0, 1'b0, 1'b0, 1'b0), 5'h0A, 1'b0);
      check(16'(irqs - n), 16'h0001);
      sleep_mode <= 1'b0;
      @(posedge mclk);
      rchk(3'h1, 16'h0011);
      rchk(3'h2, 16'h003E);
      wreg(3'h0, 16'h8000);
      n = irqs;
      send(16'h0000, 5'h10, 1'b1);
      repeat (300) @(posedge mclk);
      check(16'(irqs - n), 16'h0001);
      rchk(3'h1, 16'h0015);
      rchk(3'h2, 16'h0000);
      rchk(3'h1, 16'h0014);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rchk(3'h1, 16'h0010);
      rchk(3'h2, 16'h0000);
      print_verdict;
   end
endmodule
